// *** verilog/pmct_defs.svh ***
// Register map, opcodes, field positions and timing for the power commands
`ifndef PMCT_DEFS_SVH
`define PMCT_DEFS_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define PMCT_OFF_CMD 32'h0000_0000
`define PMCT_OFF_SECCNT 32'h0000_0004
`define PMCT_OFF_DRVHEAD 32'h0000_0008
`define PMCT_OFF_STATUS 32'h0000_000c
`define PMCT_OFF_POWER 32'h0000_0010
`define PMCT_OFF_REMAIN 32'h0000_0014
`define PMCT_OFF_CONFIG 32'h0000_0018

// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define PMCT_OP_IDLE_NOW 8'he1
`define PMCT_OP_STBY_TMR 8'he2
`define PMCT_OP_IDLE_TMR 8'he3

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define PMCT_DRV_BIT 4
`define PMCT_ST_BUSY 7
`define PMCT_ST_READY 6
`define PMCT_ST_IRQ 0
`define PMCT_PWR_LOAD_LSB 8
`define PMCT_RST_BYTE 8'h00
`define PMCT_RST_OP 8'h00
`define PMCT_RST_DRV 1'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PMCT_CLK_HZ 20000000
`define PMCT_TICK_S 5
`define PMCT_SPINUP_S 10
`define PMCT_TMR_MIN_S 60
`define PMCT_TMR_MAX_S 1000

`endif

// *** verilog/pmct_pkg.sv ***
// State types of the power command block
`default_nettype none
package pmct_pkg;
  typedef enum logic [1:0] {
    PMCT_CMD_READY = 2'b00,
    PMCT_CMD_BUSY = 2'b01,
    PMCT_CMD_DONE = 2'b11
  } pmct_cmd_t;

  typedef enum logic [1:0] {
    PMCT_PWR_ACTIVE = 2'b00,
    PMCT_PWR_IDLE = 2'b01,
    PMCT_PWR_STANDBY = 2'b11,
    PMCT_PWR_SPINUP = 2'b10
  } pmct_pwr_t;
endpackage
`default_nettype wire

// *** verilog/pmct_top.sv ***
// Power command interpreter with auto power-down timer and APB registers
//
// Decided for this implementation: the register addresses and the APB register port.
`include "pmct_defs.svh"
`default_nettype none
// How it works
// - Idle-immediate: busy, idle, unbusy, interrupt
// - Idle switches off non-essential circuitry
// - Idle serves media access with no delay
// - Standby-with-timer: busy, standby, unbusy, interrupt
// - Standby spins up, media late up to 10s
// - Ready bit always stays set
// - Nonzero count arms timer after last command
// - Zero count disables auto power-down
// - Five seconds per unit, 60 to 1000 s
// - Idle-with-timer: busy, idle, unbusy, interrupt
// - Countdown restarts per command; expiry means standby
// - Timer value comes from sector count
module pmct_top
  import pmct_pkg::*;
#(
  parameter int TICK_CYCLES = `PMCT_TICK_S * `PMCT_CLK_HZ,
  parameter int SPINUP_CYCLES = `PMCT_SPINUP_S * `PMCT_CLK_HZ
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mediaReq,
  input wire logic cmdDone,
  output logic mediaGo,
  output logic hostIrq,
  output logic busy,
  output logic ready,
  output logic auxPowerOn,
  output logic spindleOn
);

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam logic [7:0] MIN_UNITS = 8'(`PMCT_TMR_MIN_S / `PMCT_TICK_S);
  localparam logic [7:0] MAX_UNITS = 8'(`PMCT_TMR_MAX_S / `PMCT_TICK_S);
  localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES - 1);
  localparam logic [27:0] SPIN_LAST = 28'(SPINUP_CYCLES - 1);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  pmct_cmd_t cmdState;
  pmct_cmd_t next_cmdState;
  pmct_pwr_t pwr;
  pmct_pwr_t next_pwr;
  logic [7:0] secCnt;
  logic [7:0] drvHead;
  logic [7:0] lastOp;
  logic drivePos;
  logic [7:0] timerLoad;
  logic [7:0] next_timerLoad;
  logic [7:0] remain;
  logic [7:0] next_remain;
  logic [27:0] tickCnt;
  logic [27:0] next_tickCnt;
  logic [27:0] spinCnt;
  logic irqPend;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire accPend = psel & penable & ~pready;
  wire acc = psel & penable & pready;
  wire wrEn = acc & pwrite;
  wire rdEn = acc & ~pwrite;
  wire hitCmd = paddr == `PMCT_OFF_CMD;
  wire hitSecCnt = paddr == `PMCT_OFF_SECCNT;
  wire hitDrvHead = paddr == `PMCT_OFF_DRVHEAD;
  wire hitStatus = paddr == `PMCT_OFF_STATUS;
  wire hitPower = paddr == `PMCT_OFF_POWER;
  wire hitRemain = paddr == `PMCT_OFF_REMAIN;
  wire hitConfig = paddr == `PMCT_OFF_CONFIG;
  wire mapped = hitCmd | hitSecCnt | hitDrvHead | hitStatus | hitPower |
    hitRemain | hitConfig;

  wire [7:0] statusByte = {busy, ready, 5'h00, irqPend};
  wire [31:0] powerWord = {16'h0000, timerLoad, 6'h00, pwr};
  wire [31:0] rdMux =
    hitCmd ? {24'h000000, lastOp} :
    hitSecCnt ? {24'h000000, secCnt} :
    hitDrvHead ? {24'h000000, drvHead} :
    hitStatus ? {24'h000000, statusByte} :
    hitPower ? powerWord :
    hitRemain ? {24'h000000, remain} :
    hitConfig ? {31'h00000000, drivePos} :
    32'h0000_0000;

  // ------------------------------------------------------------
  // Command acceptance
  // ------------------------------------------------------------
  wire [7:0] opIn = pwdata[7:0];
  wire opKnown = (opIn == `PMCT_OP_IDLE_NOW) |
    (opIn == `PMCT_OP_STBY_TMR) | (opIn == `PMCT_OP_IDLE_TMR);
  wire driveMatch = drvHead[`PMCT_DRV_BIT] == drivePos;
  wire accept = wrEn & hitCmd & opKnown & driveMatch &
    (cmdState == PMCT_CMD_READY);
  wire applyCmd = cmdState == PMCT_CMD_BUSY;
  wire finishCmd = cmdState == PMCT_CMD_DONE;
  wire statusRead = rdEn & hitStatus;

  // Out-of-range nonzero counts are pulled into the usable period
  function automatic logic [7:0] clampUnits(input logic [7:0] units);
    logic [7:0] res;
    res = units;
    if (units == 8'h00) begin
      res = 8'h00;
    end else if (units < MIN_UNITS) begin
      res = MIN_UNITS;
    end else if (units > MAX_UNITS) begin
      res = MAX_UNITS;
    end
    return res;
  endfunction

  wire [7:0] loadUnits = clampUnits(secCnt);

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_cmdState = cmdState;
    case (cmdState)
      PMCT_CMD_READY: begin
        if (accept) begin
          next_cmdState = PMCT_CMD_BUSY;
        end
      end
      PMCT_CMD_BUSY: begin
        next_cmdState = PMCT_CMD_DONE;
      end
      PMCT_CMD_DONE: begin
        next_cmdState = PMCT_CMD_READY;
      end
      default: begin
        next_cmdState = PMCT_CMD_READY;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Countdown timer
  // ------------------------------------------------------------
  wire spinDone = (pwr == PMCT_PWR_SPINUP) & (spinCnt == SPIN_LAST);
  wire timerRestart = finishCmd | cmdDone | mediaReq | spinDone;
  wire awake = (pwr == PMCT_PWR_ACTIVE) | (pwr == PMCT_PWR_IDLE);
  wire timerRun = awake & (timerLoad != 8'h00) & (remain != 8'h00) &
    (cmdState == PMCT_CMD_READY);
  wire tick = timerRun & (tickCnt == TICK_LAST);
  wire expire = tick & (remain == 8'h01) & ~timerRestart;

  always_comb begin
    next_timerLoad = timerLoad;
    if (applyCmd & (lastOp != `PMCT_OP_IDLE_NOW)) begin
      next_timerLoad = loadUnits;
    end
  end

  always_comb begin
    next_remain = remain;
    next_tickCnt = tickCnt;
    if (timerRestart) begin
      next_remain = timerLoad;
      next_tickCnt = 28'h0000000;
    end else if (tick) begin
      next_remain = remain - 8'h01;
      next_tickCnt = 28'h0000000;
    end else if (timerRun) begin
      next_tickCnt = tickCnt + 28'h0000001;
    end
  end

  // ------------------------------------------------------------
  // Power state
  // ------------------------------------------------------------
  always_comb begin
    next_pwr = pwr;
    if (applyCmd) begin
      if (lastOp == `PMCT_OP_STBY_TMR) begin
        next_pwr = PMCT_PWR_STANDBY;
      end else begin
        next_pwr = PMCT_PWR_IDLE;
      end
    end else if (spinDone) begin
      next_pwr = PMCT_PWR_IDLE;
    end else if (mediaReq & (pwr == PMCT_PWR_STANDBY)) begin
      next_pwr = PMCT_PWR_SPINUP;
    end else if (expire) begin
      next_pwr = PMCT_PWR_STANDBY;
    end
  end

  wire goNow = mediaReq & awake & ~applyCmd;
  wire next_mediaGo = goNow | (spinDone & ~applyCmd);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      cmdState <= PMCT_CMD_READY;
      pwr <= PMCT_PWR_ACTIVE;
      timerLoad <= `PMCT_RST_BYTE;
      remain <= `PMCT_RST_BYTE;
      tickCnt <= 28'h0000000;
    end else begin
      cmdState <= next_cmdState;
      pwr <= next_pwr;
      timerLoad <= next_timerLoad;
      remain <= next_remain;
      tickCnt <= next_tickCnt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      spinCnt <= 28'h0000000;
    end else if (pwr == PMCT_PWR_SPINUP) begin
      spinCnt <= spinCnt + 28'h0000001;
    end else begin
      spinCnt <= 28'h0000000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      secCnt <= `PMCT_RST_BYTE;
      drvHead <= `PMCT_RST_BYTE;
      drivePos <= `PMCT_RST_DRV;
    end else begin
      if (wrEn & hitSecCnt) begin
        secCnt <= pwdata[7:0];
      end
      if (wrEn & hitDrvHead) begin
        drvHead <= pwdata[7:0];
      end
      if (wrEn & hitConfig) begin
        drivePos <= pwdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lastOp <= `PMCT_RST_OP;
    end else if (accept) begin
      lastOp <= opIn;
    end
  end

  // Busy from acceptance until the power change is done
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'h0;
    end else if (accept) begin
      busy <= 1'h1;
    end else if (finishCmd) begin
      busy <= 1'h0;
    end
  end

  // Interrupt set on completion wins over a status read
  always_ff @(posedge clk) begin
    if (reset) begin
      irqPend <= 1'h0;
      hostIrq <= 1'h0;
    end else if (finishCmd) begin
      irqPend <= 1'h1;
      hostIrq <= 1'h1;
    end else if (statusRead) begin
      irqPend <= 1'h0;
      hostIrq <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ready <= 1'h1;
      auxPowerOn <= 1'h1;
      spindleOn <= 1'h1;
      mediaGo <= 1'h0;
    end else begin
      ready <= 1'h1;
      auxPowerOn <= next_pwr == PMCT_PWR_ACTIVE;
      spindleOn <= next_pwr != PMCT_PWR_STANDBY;
      mediaGo <= next_mediaGo;
    end
  end

  // ------------------------------------------------------------
  // APB answer: one wait state, read data captured with it
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= accPend;
      pslverr <= accPend & ~mapped;
      if (accPend & ~pwrite) begin
        prdata <= rdMux;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/pmct_top_props.sv ***
// Port checker for the power command block
`default_nettype none
module pmct_top_props
  import pmct_pkg::*;
#(
  parameter int SPINUP_CYCLES = 8
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic mediaReq,
  input wire logic mediaGo,
  input wire logic hostIrq,
  input wire logic busy,
  input wire logic ready,
  input wire logic auxPowerOn,
  input wire logic spindleOn
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GO_MAX = SPINUP_CYCLES + 4;
  logic waking;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Spin-up in progress
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset)
      waking <= 1'b0;
    else if (mediaReq && !spindleOn && !busy)
      waking <= 1'b1;
    else if (mediaGo)
      waking <= 1'b0;
  end
  property p_rdy; ready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_cmd; $rose(busy) |=> busy ##1 (!busy && hostIrq); endproperty
  a_cmd: assert property (p_cmd) else $error("busy window");
  property p_irq; $rose(hostIrq) |-> $fell(busy); endproperty
  a_irq: assert property (p_irq) else $error("irq without end");
  property p_aux; $rose(hostIrq) |-> !auxPowerOn; endproperty
  a_aux: assert property (p_aux) else $error("aux left on");
  property p_stby; !spindleOn |-> !auxPowerOn; endproperty
  a_stby: assert property (p_stby) else $error("aux in standby");
  property p_go; mediaReq && spindleOn && !busy && !waking |=> mediaGo;
  endproperty
  a_go: assert property (p_go) else $error("idle access late");
  property p_wake;
    mediaReq && !spindleOn && !busy && !waking |-> ##[1:GO_MAX] mediaGo;
  endproperty
  a_wake: assert property (p_wake) else $error("wake too slow");
  property p_ack; psel && !penable |=> ##1 pready; endproperty
  a_ack: assert property (p_ack) else $error("no pready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
endmodule
bind pmct_top pmct_top_props #(.SPINUP_CYCLES(SPINUP_CYCLES)) props_u (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .mediaReq(mediaReq), .mediaGo(mediaGo),
  .hostIrq(hostIrq), .busy(busy), .ready(ready),
  .auxPowerOn(auxPowerOn), .spindleOn(spindleOn)
);
`default_nettype wire

// *** bench/pmct_media_host.sv ***
// Media-side partner: pulses requests and counts grants
`default_nettype none
module pmct_media_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic wantMedia,
  input wire logic wantDone,
  input wire logic mediaGo,
  output logic mediaReq,
  output logic cmdDone,
  output logic [7:0] goCount
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) begin
    if (reset) begin
      mediaReq <= 1'b0;
      cmdDone <= 1'b0;
      goCount <= 8'h00;
    end else begin
      mediaReq <= wantMedia;
      cmdDone <= wantDone;
      if (mediaGo)
        goCount <= goCount + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the power command block
`include "pmct_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;
  localparam logic [7:0] MIN_U = 8'(`PMCT_TMR_MIN_S / `PMCT_TICK_S);
  localparam logic [7:0] MAX_U = 8'(`PMCT_TMR_MAX_S / `PMCT_TICK_S);
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdat;
  logic pready, pslverr, mediaReq, cmdDone, mediaGo, hostIrq, busy;
  logic ready, auxPowerOn, spindleOn, rerr, wantMedia = 0, wantDone = 0;
  logic [7:0] goCount;
  int err_total = 0, checks_done = 0;
  longint tStart;
  always #25 clk = ~clk;
  pmct_top #(.TICK_CYCLES(TICK), .SPINUP_CYCLES(8)) dut_u (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mediaReq(mediaReq), .cmdDone(cmdDone),
    .mediaGo(mediaGo), .hostIrq(hostIrq), .busy(busy), .ready(ready),
    .auxPowerOn(auxPowerOn), .spindleOn(spindleOn));
  pmct_media_host host_u (.clk(clk), .reset(reset), .wantMedia(wantMedia),
    .wantDone(wantDone), .mediaGo(mediaGo), .mediaReq(mediaReq),
    .cmdDone(cmdDone), .goCount(goCount));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poke(input logic media);
    int n;
    n = 0;
    @(posedge clk);
    if (media) wantMedia <= 1'b1;
    else wantDone <= 1'b1;
    @(posedge clk);
    wantMedia <= 1'b0;
    wantDone <= 1'b0;
    tStart = $time / 50;
    while (media && n < 30 && mediaGo !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    if (media) tStart = $time / 50;
  endtask
  task automatic cmd(input logic [7:0] op, sec);
    int n;
    n = 0;
    apb(1, `PMCT_OFF_SECCNT, {24'h0, sec});
    apb(1, `PMCT_OFF_CMD, {24'h0, op});
    while (hostIrq !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    tStart = $time / 50;
    apb(0, `PMCT_OFF_STATUS, 0);
    chk(rdat, 32'h41);
    apb(0, `PMCT_OFF_STATUS, 0);
    chk(rdat, 32'h40);
  endtask
  task automatic settle(input logic [7:0] ld);
    int n;
    n = 0;
    while (spindleOn === 1'b1 && n < 900) begin
      @(posedge clk);
      n++;
    end
    n = int'($time / 50 - tStart);
    if (ld == 0) chk(32'(spindleOn), 1);
    else chk(32'(n >= ld * TICK - 3 && n <= ld * TICK + 4), 1);
  endtask
  function automatic logic [7:0] exp_load(input logic [7:0] s);
    if (s == 0) return 8'h00;
    if (s < MIN_U) return MIN_U;
    if (s > MAX_U) return MAX_U;
    return s;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] sec, op, ld;
    void'($urandom(33961));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk({ready, auxPowerOn, spindleOn}, 3'b111);
    apb(1, `PMCT_OFF_DRVHEAD, 32'h10);
    apb(1, `PMCT_OFF_CMD, 32'he1);
    repeat (4) @(posedge clk);
    chk(32'(busy), 0);
    chk(32'(hostIrq), 0);
    apb(1, `PMCT_OFF_DRVHEAD, 0);
    cmd(`PMCT_OP_IDLE_NOW, 8'h30);
    apb(0, `PMCT_OFF_POWER, 0);
    chk(rdat, 32'h1);
    chk(32'(auxPowerOn), 0);
    poke(1);
    @(posedge clk);
    chk(32'(goCount), 1);
    apb(0, 32'h40, 0);
    chk(32'(rerr), 1);
    chk(rdat, 32'h0);
    for (int i = 0; i < 8; i++) begin
      sec = i < 4 ? (i == 0 || i == 3 ? 8'h00 : i == 1 ? 8'h05 : 8'hfa)
                  : 8'($urandom_range(1, 255));
      op = i % 2 ? `PMCT_OP_STBY_TMR : `PMCT_OP_IDLE_TMR;
      ld = exp_load(sec);
      cmd(op, sec);
      apb(0, `PMCT_OFF_POWER, 0);
      chk(rdat, {16'h0, ld, 6'h0, ~op[0], 1'b1});
      if (op == `PMCT_OP_STBY_TMR) begin
        poke(1);
        apb(0, `PMCT_OFF_POWER, 0);
        chk(rdat[1:0], 2'b01);
      end else if (ld != 0) begin
        repeat (20) @(posedge clk);
        poke(0);
      end
      settle(ld);
    end
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
